/* logic/dyc_pkg.sv */
package dyc_pkg;

  // widths and formats
  localparam int SMP_W   = 24;
  localparam int FRAC    = 23;
  localparam int COEF_W  = 26;
  localparam int DATA_W  = 32;
  localparam int IDX_W   = 10;
  localparam int ADDR_W  = IDX_W + 2;
  localparam int STRB_W  = DATA_W / 8;

  // channel and compressor layout
  localparam int NUM_CH   = 3;
  localparam int NUM_SAT  = 2;
  localparam int NUM_CMP  = 2;
  localparam int CH_SAT_L = 0;
  localparam int CH_SAT_R = 1;
  localparam int CH_SUB   = 2;
  localparam int CMP_SAT  = 0;
  localparam int CMP_SUB  = 1;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL      = 10'h046;
  localparam logic [IDX_W-1:0] IDX_PRM_BASE  = 10'h048;
  localparam logic [IDX_W-1:0] IDX_GAIN_BASE = 10'h05A;

  // control bits, bit position equals compressor number
  localparam int CTRL_W      = 2;
  localparam int CTRL_SAT_EN = 0;
  localparam int CTRL_SUB_EN = 1;

  // parameter fields inside one compressor block
  localparam int NUM_FLD   = 9;
  localparam int FLD_THR   = 0;
  localparam int FLD_OFS   = 1;
  localparam int FLD_SLOPE = 2;
  localparam int FLD_AVG   = 3;
  localparam int FLD_AVG_C = 4;
  localparam int FLD_ATK   = 5;
  localparam int FLD_ATK_C = 6;
  localparam int FLD_DEC   = 7;
  localparam int FLD_DEC_C = 8;

  // reset values and fixed-point constants
  localparam logic [DATA_W-1:0] RST_THR   = 32'h0550_A3D7;
  localparam logic [DATA_W-1:0] RST_OFS   = 32'h0008_4210;
  localparam logic [DATA_W-1:0] UNITY     = 32'h0080_0000;
  localparam logic [DATA_W-1:0] ZERO_W    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_THR  = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] MASK_COEF = 32'h03FF_FFFF;
  localparam logic signed [31:0] LOG_FLOOR = 32'sh7FFF_FFFF;
  localparam logic signed [63:0] GAIN_MAX  = 64'sh0000_0000_01FF_FFFF;
  localparam logic [7:0]        NORM_Q    = 8'h7C;
  localparam int                NORM_SH   = 3;
  localparam int                EXP_MAX   = 40;
  localparam int                EXP_MIN   = 8;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [DATA_W-1:0] fld_mask(input int f);
    return (f == FLD_THR) ? MASK_THR : MASK_COEF;
  endfunction

  function automatic logic [DATA_W-1:0] fld_rst(input int f);
    case (f)
      FLD_THR:                  return RST_THR;
      FLD_OFS:                  return RST_OFS;
      FLD_AVG, FLD_ATK, FLD_DEC: return UNITY;
      default:                  return ZERO_W;
    endcase
  endfunction

endpackage

/* logic/dyc_rms_est.sv */
`timescale 1ns/10ps
module dyc_rms_est (
  // clock and reset
  input  logic                                    aclk,
  input  logic                                    aresetn,
  // sample in
  input  logic                                    smp_valid,
  input  logic signed [dyc_pkg::SMP_W-1:0]        smp,
  // averaging weights
  input  logic signed [dyc_pkg::COEF_W-1:0]       avg_w,
  input  logic signed [dyc_pkg::COEF_W-1:0]       avg_wc,
  // mean-square estimate
  output logic        [dyc_pkg::DATA_W-1:0]       est_nx,
  output logic        [dyc_pkg::DATA_W-1:0]       est_q
);
  import dyc_pkg::*;

  logic signed [2*SMP_W-1:0] sq;
  logic        [DATA_W-1:0]  sq_n;
  logic signed [63:0]        acc;
  logic signed [63:0]        acc_sh;

  assign sq     = smp * smp;
  assign sq_n   = DATA_W'(sq >>> (SMP_W - 1));
  // new square weighted by avg_w, old estimate by avg_wc
  assign acc    = 64'(avg_w) * $signed(64'(sq_n)) + 64'(avg_wc) * $signed(64'(est_q));
  assign acc_sh = acc >>> FRAC;

  always_comb begin
    if (acc_sh < 0) begin
      est_nx = '0;
    end else if (|acc_sh[63:DATA_W]) begin
      est_nx = '1;
    end else begin
      est_nx = acc_sh[DATA_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      est_q <= '0;
    end else if (smp_valid) begin
      est_q <= est_nx;
    end
  end

endmodule

/* logic/dyc_compressor.sv */
`timescale 1ns/10ps
module dyc_compressor (
  // clock and reset
  input  logic                             aclk,
  input  logic                             aresetn,
  // write address channel
  input  logic                             s_axi_awvalid,
  output logic                             s_axi_awready,
  input  logic [dyc_pkg::ADDR_W-1:0]       s_axi_awaddr,
  // write data channel
  input  logic                             s_axi_wvalid,
  output logic                             s_axi_wready,
  input  logic [dyc_pkg::DATA_W-1:0]       s_axi_wdata,
  input  logic [dyc_pkg::STRB_W-1:0]       s_axi_wstrb,
  // write response channel
  output logic                             s_axi_bvalid,
  input  logic                             s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // read address channel
  input  logic                             s_axi_arvalid,
  output logic                             s_axi_arready,
  input  logic [dyc_pkg::ADDR_W-1:0]       s_axi_araddr,
  // read data channel
  output logic                             s_axi_rvalid,
  input  logic                             s_axi_rready,
  output logic [dyc_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // post-volume samples in
  input  logic                             vol_valid,
  input  logic signed [dyc_pkg::SMP_W-1:0] vol_sat_left,
  input  logic signed [dyc_pkg::SMP_W-1:0] vol_sat_right,
  input  logic signed [dyc_pkg::SMP_W-1:0] vol_sub,
  // compressed samples out
  output logic                             out_valid,
  output logic signed [dyc_pkg::SMP_W-1:0] out_sat_left,
  output logic signed [dyc_pkg::SMP_W-1:0] out_sat_right,
  output logic signed [dyc_pkg::SMP_W-1:0] out_sub
);
  import dyc_pkg::*;

  logic                      aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
  logic [1:0]                bresp_q;
  logic [IDX_W-1:0]          aw_idx_q;
  logic [DATA_W-1:0]         w_data_q;
  logic [STRB_W-1:0]         w_strb_q;
  logic                      aw_take, w_take, do_write, bvalid_d, aw_full_d, w_full_d;
  logic                      arready_q, rvalid_q, ar_take, rvalid_d;
  logic [DATA_W-1:0]         rdata_q, rd_data;
  logic [1:0]                rresp_q;
  logic [IDX_W-1:0]          rd_idx;
  logic                      rd_ok, wr_ok;
  logic [CTRL_W-1:0]         ctrl_q;
  logic [DATA_W-1:0]         prm_q [NUM_CMP][NUM_FLD];
  logic signed [SMP_W-1:0]   smp_in [NUM_CH];
  logic signed [SMP_W-1:0]   out_q [NUM_CH];
  logic                      out_valid_q;
  logic [DATA_W-1:0]         est_nx [NUM_CH];
  logic [DATA_W-1:0]         lvl [NUM_CMP];
  logic                      above [NUM_CMP];
  logic signed [63:0]        att [NUM_CMP];
  logic [DATA_W-1:0]         tgt [NUM_CMP];
  logic [DATA_W-1:0]         gain_d [NUM_CMP];
  logic [DATA_W-1:0]         gain_q [NUM_CMP];

  function automatic logic [IDX_W-1:0] prm_idx(input int c, input int f);
    return IDX_PRM_BASE + IDX_W'(c * NUM_FLD + f);
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                               input logic [DATA_W-1:0] nw,
                                               input logic [STRB_W-1:0] st);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // -log2 of mean square in 9.23, one unit is 3.0103 dB of attenuation
  function automatic logic signed [31:0] neg_log2(input logic [DATA_W-1:0] ms);
    int                p;
    logic [DATA_W-1:0] nrm;
    p = 0;
    for (int i = 0; i < DATA_W; i++) begin
      if (ms[i]) begin
        p = i;
      end
    end
    nrm = ms << (DATA_W - 1 - p);
    if (ms == '0) begin
      return LOG_FLOOR;
    end
    return 32'((FRAC - p) <<< FRAC) - 32'(nrm[DATA_W-2 -: FRAC]);
  endfunction

  function automatic logic [DATA_W-1:0] clamp_gain(input logic signed [63:0] v);
    if (v < 0) begin
      return '0;
    end else if (v > GAIN_MAX) begin
      return DATA_W'(GAIN_MAX);
    end
    return v[DATA_W-1:0];
  endfunction

  function automatic logic signed [SMP_W-1:0] scale_smp(input logic signed [SMP_W-1:0] s,
                                                         input logic [DATA_W-1:0]     g);
    logic signed [63:0] p;
    logic signed [63:0] lim;
    p   = (64'(s) * $signed(64'(g))) >>> FRAC;
    lim = 64'sd1 <<< (SMP_W - 1);
    if (p >= lim) begin
      return {1'b0, {(SMP_W-1){1'b1}}};
    end else if (p < -lim) begin
      return {1'b1, {(SMP_W-1){1'b0}}};
    end
    return p[SMP_W-1:0];
  endfunction

  // write path: address and data taken in either order
  assign aw_take   = s_axi_awvalid & awready_q;
  assign w_take    = s_axi_wvalid & wready_q;
  assign do_write  = aw_full_q & w_full_q & ~bvalid_q;
  assign bvalid_d  = do_write | (bvalid_q & ~s_axi_bready);
  assign aw_full_d = ~do_write & (aw_full_q | aw_take);
  assign w_full_d  = ~do_write & (w_full_q | w_take);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_idx_q  <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_take) begin
        aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_comb begin
    wr_ok = (aw_idx_q == IDX_CTRL);
    for (int c = 0; c < NUM_CMP; c++) begin
      for (int f = 0; f < NUM_FLD; f++) begin
        if (aw_idx_q == prm_idx(c, f)) begin
          wr_ok = 1'b1;
        end
      end
    end
  end

  // enable bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (do_write && aw_idx_q == IDX_CTRL && w_strb_q[0]) begin
      ctrl_q <= w_data_q[CTRL_W-1:0];
    end
  end

  // separate parameter block per compressor
  always_ff @(posedge aclk) begin
    for (int c = 0; c < NUM_CMP; c++) begin
      for (int f = 0; f < NUM_FLD; f++) begin
        if (!aresetn) begin
          prm_q[c][f] <= fld_rst(f);
        end else if (do_write && aw_idx_q == prm_idx(c, f)) begin
          prm_q[c][f] <= merge(prm_q[c][f], w_data_q, w_strb_q) & fld_mask(f);
        end
      end
    end
  end

  // read path
  assign ar_take  = s_axi_arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);

  always_comb begin
    rd_idx  = s_axi_araddr[ADDR_W-1:2];
    rd_data = '0;
    rd_ok   = 1'b0;
    if (rd_idx == IDX_CTRL) begin
      rd_data = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
      rd_ok   = 1'b1;
    end
    for (int c = 0; c < NUM_CMP; c++) begin
      for (int f = 0; f < NUM_FLD; f++) begin
        if (rd_idx == prm_idx(c, f)) begin
          rd_data = prm_q[c][f];
          rd_ok   = 1'b1;
        end
      end
      if (rd_idx == IDX_GAIN_BASE + IDX_W'(c)) begin
        rd_data = gain_q[c];
        rd_ok   = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_data;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // post-volume samples
  assign smp_in[CH_SAT_L] = vol_sat_left;
  assign smp_in[CH_SAT_R] = vol_sat_right;
  assign smp_in[CH_SUB]   = vol_sub;

  // per-channel estimator and output multiplier
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    localparam int C = (ch < NUM_SAT) ? CMP_SAT : CMP_SUB;
    dyc_rms_est u_est (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .smp_valid (vol_valid),
      .smp       (smp_in[ch]),
      .avg_w     (prm_q[C][FLD_AVG][COEF_W-1:0]),
      .avg_wc    (prm_q[C][FLD_AVG_C][COEF_W-1:0]),
      .est_nx    (est_nx[ch]),
      .est_q     ()
    );

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_q[ch] <= '0;
      end else if (vol_valid) begin
        out_q[ch] <= ctrl_q[C] ? scale_smp(smp_in[ch], gain_d[C])
                               : smp_in[ch];
      end
    end
  end

  // coefficient engine and smoother per compressor
  for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp
    localparam int FIRST = (c == CMP_SAT) ? 0 : NUM_SAT;
    localparam int LAST  = (c == CMP_SAT) ? NUM_SAT - 1 : NUM_CH - 1;
    logic signed [31:0] l_amp;
    logic signed [63:0] diff, slope, sh, nsh, mant, base, w, wc, acc;

    always_comb begin
      lvl[c] = est_nx[FIRST];
      for (int i = FIRST; i <= LAST; i++) begin
        if (est_nx[i] > lvl[c]) begin
          lvl[c] = est_nx[i];
        end
      end
    end

    always_comb begin
      l_amp    = neg_log2(lvl[c]) >>> 1;
      diff     = 64'(l_amp) - 64'($signed(prm_q[c][FLD_THR]));
      slope    = 64'($signed(prm_q[c][FLD_SLOPE][COEF_W-1:0]));
      above[c] = (diff < 0);
      att[c]   = above[c] ? (diff * slope) >>> FRAC : 64'sd0;
      sh       = att[c] >>> FRAC;
      nsh      = -sh;
      mant     = $signed(64'(UNITY)) - $signed(64'(att[c][FRAC-1:0] >> 1));
      base     = (64'($signed(prm_q[c][FLD_OFS][COEF_W-1:0])) * $signed(64'(NORM_Q))) >>> NORM_SH;
      base     = (base * mant) >>> FRAC;
      if (sh > EXP_MAX) begin
        base = 64'sd0;
      end else if (sh >= 0) begin
        base = base >>> sh[5:0];
      end else if (nsh > EXP_MIN) begin
        base = GAIN_MAX;
      end else begin
        base = base <<< nsh[3:0];
      end
      tgt[c] = clamp_gain(base);
    end

    always_comb begin
      if (tgt[c] < gain_q[c]) begin
        w  = 64'($signed(prm_q[c][FLD_ATK][COEF_W-1:0]));
        wc = 64'($signed(prm_q[c][FLD_ATK_C][COEF_W-1:0]));
      end else begin
        w  = 64'($signed(prm_q[c][FLD_DEC][COEF_W-1:0]));
        wc = 64'($signed(prm_q[c][FLD_DEC_C][COEF_W-1:0]));
      end
      acc       = w * $signed(64'(tgt[c])) + wc * $signed(64'(gain_q[c]));
      gain_d[c] = clamp_gain(acc >>> FRAC);
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        gain_q[c] <= UNITY;
      end else if (vol_valid) begin
        gain_q[c] <= ctrl_q[c] ? gain_d[c] : UNITY;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= vol_valid;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign out_valid     = out_valid_q;
  assign out_sat_left  = out_q[CH_SAT_L];
  assign out_sat_right = out_q[CH_SAT_R];
  assign out_sub       = out_q[CH_SUB];

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_out_follows : assert property (vol_valid |=> out_valid_q)
    else $error("output strobe missing after sample");
  chk_sat_scaled : assert property ((vol_valid && ctrl_q[CTRL_SAT_EN]) |=>
    out_q[CH_SAT_L] == scale_smp($past(smp_in[CH_SAT_L]), gain_q[CMP_SAT]))
    else $error("satellite output not sample times gain");
  chk_sat_bypass : assert property ((vol_valid && !ctrl_q[CTRL_SAT_EN]) |=>
    (out_q[CH_SAT_L] == $past(smp_in[CH_SAT_L]) && out_q[CH_SAT_R] == $past(smp_in[CH_SAT_R])))
    else $error("disabled satellite path altered samples");
  chk_sub_bypass : assert property ((vol_valid && !ctrl_q[CTRL_SUB_EN]) |=>
    (out_q[CH_SUB] == $past(smp_in[CH_SUB]) && gain_q[CMP_SUB] == UNITY))
    else $error("disabled subwoofer path not unity");
  chk_gang_gain : assert property ((vol_valid &&
    smp_in[CH_SAT_L] == smp_in[CH_SAT_R]) |=> out_q[CH_SAT_L] == out_q[CH_SAT_R])
    else $error("satellite channels scaled differently");
  chk_gain_stable : assert property (!vol_valid |=>
    ($stable(gain_q[CMP_SAT]) && $stable(gain_q[CMP_SUB])))
    else $error("gain moved without a sample");
  chk_flat_below : assert property (!above[CMP_SAT] |-> att[CMP_SAT] == 64'sd0)
    else $error("attenuation below threshold");
  chk_level_max : assert property (lvl[CMP_SAT] >= est_nx[CH_SAT_L] &&
    lvl[CMP_SAT] >= est_nx[CH_SAT_R])
    else $error("satellite level not the largest estimate");
  chk_ctrl_write : assert property ((do_write && aw_idx_q == IDX_CTRL &&
    w_strb_q[0]) |=> ctrl_q == $past(w_data_q[CTRL_W-1:0]))
    else $error("enable bits not written");
  chk_rd_hold : assert property ((rvalid_q && !s_axi_rready) |=> (rvalid_q && $stable(rdata_q)))
    else $error("read data dropped before rready");

  cov_sat_compress : cover property (vol_valid && ctrl_q[CTRL_SAT_EN] && above[CMP_SAT]);
  cov_attack       : cover property (vol_valid && ctrl_q[CTRL_SAT_EN] &&
    tgt[CMP_SAT] < gain_q[CMP_SAT]);
  cov_ctrl_write   : cover property (do_write && aw_idx_q == IDX_CTRL);
  cov_gain_read    : cover property (ar_take && rd_idx == IDX_GAIN_BASE);

endmodule

/* testbench/dyc_partner.sv */
`timescale 1ns/10ps
module dyc_partner (
  // clock
  input  logic                             aclk,
  // post-volume samples towards the compressor
  output logic                             vol_valid,
  output logic signed [dyc_pkg::SMP_W-1:0] vol_sat_left,
  output logic signed [dyc_pkg::SMP_W-1:0] vol_sat_right,
  output logic signed [dyc_pkg::SMP_W-1:0] vol_sub,
  // compressed samples back
  input  logic                             out_valid,
  input  logic signed [dyc_pkg::SMP_W-1:0] out_sat_left,
  input  logic signed [dyc_pkg::SMP_W-1:0] out_sat_right,
  input  logic signed [dyc_pkg::SMP_W-1:0] out_sub
);
  import dyc_pkg::*;
  logic signed [SMP_W-1:0] got [NUM_CH];
  logic                    on_time;
  initial begin
    vol_valid = 1'h0;
    vol_sat_left = '0;
    vol_sat_right = '0;
    vol_sub = '0;
  end
  // one volume-adjusted frame, sink takes the answer one cycle later
  task automatic send(input logic signed [SMP_W-1:0] l, r, s);
    @(posedge aclk);
    vol_valid <= 1'h1;
    vol_sat_left <= l;
    vol_sat_right <= r;
    vol_sub <= s;
    @(posedge aclk);
    vol_valid <= 1'h0;
    // stale lines not held past the frame
    vol_sat_left <= ~l;
    vol_sat_right <= ~r;
    vol_sub <= ~s;
    #1;
    on_time = out_valid;
    got[0] = out_sat_left;
    got[1] = out_sat_right;
    got[2] = out_sub;
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import dyc_pkg::*;
  localparam logic signed [SMP_W-1:0] LOUD = 24'sh40_0000;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, vol_valid, out_valid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd_v;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic signed [SMP_W-1:0] vl, vr, vs, ol, orr, os;
  int n_mismatch, checked;
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  dyc_compressor DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .vol_valid(vol_valid),
    .vol_sat_left(vl), .vol_sat_right(vr), .vol_sub(vs), .out_valid(out_valid),
    .out_sat_left(ol), .out_sat_right(orr), .out_sub(os));
  dyc_partner P (.aclk(aclk), .vol_valid(vol_valid), .vol_sat_left(vl), .vol_sat_right(vr),
    .vol_sub(vs), .out_valid(out_valid), .out_sat_left(ol), .out_sat_right(orr), .out_sub(os));
  task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [IDX_W-1:0] fi(input int c, input int f);
    return IDX_PRM_BASE + IDX_W'(NUM_FLD * c + f);
  endfunction
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
    logic aw_d, w_d;
    aw_d = 1'h0;
    w_d = 1'h0;
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr <= {idx, 2'h0};
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (!aw_d && awready === 1'h1) begin
        aw_d = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_d && wready === 1'h1) begin
        w_d = 1'h1;
        wvalid <= 1'h0;
      end
      if (bvalid === 1'h1) begin
        rsp = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx);
    logic ar_d;
    ar_d = 1'h0;
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= {idx, 2'h0};
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (!ar_d && arready === 1'h1) begin
        ar_d = 1'h1;
        arvalid <= 1'h0;
      end
      if (rvalid === 1'h1) begin
        rd_v = rdata;
        rsp = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rchk(input string n, input logic [IDX_W-1:0] idx,
                      input logic [DATA_W-1:0] e, input logic [1:0] er);
    rd(idx);
    check(n, rd_v, e);
    check({n, " resp"}, {30'h0, rsp}, {30'h0, er});
  endtask
  task automatic wchk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d,
                      input logic [1:0] er);
    wr(idx, d);
    check("write resp", {30'h0, rsp}, {30'h0, er});
  endtask
  // gain status must lie within a band
  task automatic lvl(input string n, input int c, input logic [DATA_W-1:0] lo, hi);
    rd(IDX_GAIN_BASE + IDX_W'(c));
    check(n, {31'h0, rd_v >= lo && rd_v <= hi}, 32'h1);
  endtask
  task automatic pass(input logic signed [SMP_W-1:0] l, r, s);
    P.send(l, r, s);
    check("on time", {31'h0, P.on_time}, 32'h1);
    check("left", P.got[0], l);
    check("right", P.got[1], r);
    check("sub", P.got[2], s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    n_mismatch++;
    test_done;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rchk("ctrl", IDX_CTRL, 32'h0, RESP_OKAY);
    rchk("sat thr", fi(CMP_SAT, FLD_THR), RST_THR, RESP_OKAY);
    rchk("sub ofs", fi(CMP_SUB, FLD_OFS), RST_OFS, RESP_OKAY);
    rchk("sat slope", fi(CMP_SAT, FLD_SLOPE), 32'h0, RESP_OKAY);
    rchk("dec comp", fi(CMP_SAT, FLD_DEC_C), 32'h0, RESP_OKAY);
    rchk("unmapped", 10'h3FF, 32'h0, RESP_SLVERR);
    wchk(10'h3FF, 32'h1, RESP_SLVERR);
    wchk(IDX_GAIN_BASE, 32'h0, RESP_SLVERR);
    rchk("gain ro", IDX_GAIN_BASE, UNITY, RESP_OKAY);
    wchk(fi(CMP_SUB, FLD_SLOPE), 32'hFFFF_FFFF, RESP_OKAY);
    rchk("slope width", fi(CMP_SUB, FLD_SLOPE), MASK_COEF, RESP_OKAY);
    wchk(fi(CMP_SUB, FLD_SLOPE), 32'h0, RESP_OKAY);
    wchk(fi(CMP_SUB, FLD_THR), 32'h1234_5678, RESP_OKAY);
    rchk("thr width", fi(CMP_SUB, FLD_THR), 32'h1234_5678, RESP_OKAY);
    wchk(fi(CMP_SUB, FLD_THR), RST_THR, RESP_OKAY);
    pass(LOUD, -LOUD, 24'sh12_3456);
    // two-to-one cut on the satellites only
    wchk(fi(CMP_SAT, FLD_SLOPE), 32'h03C0_0000, RESP_OKAY);
    wchk(IDX_CTRL, 32'h1, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      P.send(24'sh10, 24'sh10, 24'sh10);
      lvl("sat idle", CMP_SAT, 32'h007F_0000, 32'h0081_0000);
      P.send(k ? 24'sh0 : LOUD, k ? LOUD : 24'sh0, LOUD);
      check("sub bypass", P.got[2], LOUD);
      lvl("sat cut", CMP_SAT, 32'h0, 32'h007F_0000);
    end
    lvl("sub off", CMP_SUB, UNITY, UNITY);
    P.send(LOUD, LOUD, 24'sh0);
    check("ganged", P.got[1], P.got[0]);
    check("reduced", {31'h0, P.got[0] < LOUD}, 32'h1);
    wchk(IDX_CTRL, 32'h3, RESP_OKAY);
    P.send(LOUD, LOUD, LOUD);
    lvl("sub flat", CMP_SUB, 32'h007F_0000, 32'h0081_0000);
    lvl("sat steep", CMP_SAT, 32'h0, 32'h007F_0000);
    // half-weight attack halves the first step down
    wchk(fi(CMP_SAT, FLD_ATK), 32'h0040_0000, RESP_OKAY);
    wchk(fi(CMP_SAT, FLD_ATK_C), 32'h0040_0000, RESP_OKAY);
    P.send(24'sh10, 24'sh10, 24'sh10);
    P.send(LOUD, LOUD, LOUD);
    lvl("attack", CMP_SAT, 32'h0040_0000, 32'h0048_0000);
    wchk(IDX_CTRL, 32'h0, RESP_OKAY);
    pass(LOUD, 24'sh7F_FFFF, 24'sh80_0000);
    lvl("gain reset", CMP_SAT, UNITY, UNITY);
    test_done;
  end
endmodule
